/* core/tsp_pkg.sv */
// Shared constants and carrier types of the touch ADC serial port.
package tsp_pkg;

    // ==========================================================
    // Control word layout
    localparam int CW_BITS = 8;
    localparam int START_POS = 7;
    localparam int CH_HI = 6;
    localparam int CH_LO = 4;
    localparam int RES_POS = 3;
    localparam int SE_POS = 2;
    localparam int PW_HI_POS = 1;
    localparam int PW_LO_POS = 0;

    // ==========================================================
    // Sequencing counts, in serial clock edges after the start bit
    localparam int CNT_W = 5;
    localparam logic [4:0] CNT_MAX = 5'h1F;
    localparam logic [4:0] EDGE_FIRST = 5'h01;
    localparam logic [4:0] EDGE_CH = 5'h04;
    localparam logic [4:0] EDGE_ACQ = 5'h06;
    localparam logic [4:0] EDGE_WORD = 5'h08;
    localparam logic [4:0] EDGE_MSB = 5'h09;
    localparam logic [4:0] EDGE_PWR = 5'h04;
    localparam logic [4:0] EDGE_ALERT = 5'h04;
    localparam logic [4:0] REARM_12 = 5'h0F;
    localparam logic [4:0] REARM_8 = 5'h0B;
    localparam logic [4:0] LEN_12 = 5'h0C;
    localparam logic [4:0] LEN_8 = 5'h08;
    localparam int RES_W = 12;
    // Pin idle levels {clock, select, data, touch}; select idles high.
    localparam logic [3:0] PIN_IDLE = 4'h4;

    // ==========================================================
    // Register map
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_TEST = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] TEST_RESET = 32'h0000_0000;
    localparam int CTRL_TEST_POS = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ==========================================================
    // Bus carriers
    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } tsp_axi_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tsp_axi_rsp_type;

endpackage

/* core/tsp_sync.sv */
// Two-stage synchroniser for a group of asynchronous inputs.
`timescale 1ns/10ps
module tsp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] safe;
    } tsp_sync_state_type;

    tsp_sync_state_type st;
    tsp_sync_state_type next_st;

    always_comb begin
        next_st.meta = async_in;
        next_st.safe = st.meta;
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            // Start at the pin's idle level so no false edge follows reset.
            st.meta <= RESET_VAL;
            st.safe <= RESET_VAL;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.safe;
endmodule

/* core/tsp_axi_slave.sv */
// AXI4-Lite register slave holding control, test data and status.
`timescale 1ns/10ps
module tsp_axi_slave
    import tsp_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    // Bus
    input wire tsp_axi_req_type axi_req_in,
    output tsp_axi_rsp_type axi_rsp_out,
    // Block side
    input wire logic [31:0] status_in,
    output logic [31:0] ctrl_out,
    output logic [31:0] test_out
);
    typedef struct packed {
        tsp_axi_rsp_type rsp;
        logic aw_held;
        logic w_held;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [31:0] ctrl;
        logic [31:0] test;
    } tsp_axi_state_type;

    tsp_axi_state_type st;
    tsp_axi_state_type next_st;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    always_comb begin
        next_st = st;
        if (axi_req_in.awvalid && st.rsp.awready) begin
            next_st.aw_held = 1'b1;
            next_st.awaddr = axi_req_in.awaddr;
            next_st.rsp.awready = 1'b0;
        end
        if (axi_req_in.wvalid && st.rsp.wready) begin
            next_st.w_held = 1'b1;
            next_st.wdata = axi_req_in.wdata;
            next_st.wstrb = axi_req_in.wstrb;
            next_st.rsp.wready = 1'b0;
        end
        if (st.aw_held && st.w_held && !st.rsp.bvalid) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.rsp.bvalid = 1'b1;
            next_st.rsp.bresp = RESP_OKAY;
            if (st.awaddr == REG_CTRL) begin
                next_st.ctrl = merge(st.ctrl, st.wdata, st.wstrb);
            end else if (st.awaddr == REG_TEST) begin
                next_st.test = merge(st.test, st.wdata, st.wstrb);
            end else if (st.awaddr != REG_STATUS) begin
                next_st.rsp.bresp = RESP_DECERR;
            end
        end
        if (st.rsp.bvalid && axi_req_in.bready) begin
            next_st.rsp.bvalid = 1'b0;
            next_st.rsp.awready = 1'b1;
            next_st.rsp.wready = 1'b1;
        end
        if (axi_req_in.arvalid && st.rsp.arready) begin
            next_st.rsp.arready = 1'b0;
            next_st.rsp.rvalid = 1'b1;
            next_st.rsp.rresp = RESP_OKAY;
            if (axi_req_in.araddr == REG_CTRL) begin
                next_st.rsp.rdata = st.ctrl;
            end else if (axi_req_in.araddr == REG_TEST) begin
                next_st.rsp.rdata = st.test;
            end else if (axi_req_in.araddr == REG_STATUS) begin
                next_st.rsp.rdata = status_in;
            end else begin
                next_st.rsp.rdata = 32'h0000_0000;
                next_st.rsp.rresp = RESP_DECERR;
            end
        end
        if (st.rsp.rvalid && axi_req_in.rready) begin
            next_st.rsp.rvalid = 1'b0;
            next_st.rsp.arready = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st <= '0;
            st.rsp.awready <= 1'b1;
            st.rsp.wready <= 1'b1;
            st.rsp.arready <= 1'b1;
            st.ctrl <= CTRL_RESET;
            st.test <= TEST_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign axi_rsp_out = st.rsp;
    assign ctrl_out = st.ctrl;
    assign test_out = st.test;
endmodule

/* core/tsp_top.sv */
// Serial control and conversion sequencer of the touch screen ADC.
//
// Contract
// - Select falling enables busy and data outputs.
// - Control bits sampled on rising serial clock.
// - Nothing happens until a high start bit.
// - Word complete after acquisition, hold, busy high.
// - Busy drops at the next falling edge.
// - Data output low during control bits.
// - Result MSB leaves on ninth falling edge.
// - Nine zeros, twelve bits, trailing zeros.
// - Ratiometric keeps switches on while converting.
// - Select rising floats outputs, aborts conversion.
// - Select held low awaits next start bit.
// - Twelve-bit rearm at eighth rising edge.
// - Eight-bit rearm at fourth rising edge.
// - Next word accepted while result shifts out.
// - Fifteen-clock overlapped cycles are supported.
// - Eight-bit conversion ends four clocks earlier.
// - Power up falling 4, down at end.
// - Enabled pen touch pulls alert low.
// - Pen enabled at reset, start disables it.
// - Alert releases at fourth falling edge.
// - Pen re-enabled only after conversion ends or select rises.
// - Word: start, channel, resolution, mode, power.
// - Resolution bit zero twelve, one eight.
// - Power bits select power-down and pen enable.
`timescale 1ns/10ps
module tsp_top
    import tsp_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    // Register bus
    input wire tsp_axi_req_type axi_req_in,
    output tsp_axi_rsp_type axi_rsp_out,
    // Serial pins
    input wire logic serial_clock_in,
    input wire logic chip_select_n_in,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe_out,
    output logic busy_out,
    output logic busy_oe_out,
    output logic touch_alert_n_out,
    output logic touch_alert_n_oe_out,
    // Converter core
    input wire logic [RES_W-1:0] conv_result_in,
    input wire logic pen_touch_in,
    output logic [2:0] channel_select_out,
    output logic single_ended_select_out,
    output logic switch_on_out,
    output logic track_hold_out,
    output logic power_up_out
);
    // ==========================================================
    // State
    typedef struct packed {
        logic sclk_d;
        logic active;
        logic capturing;
        logic [CNT_W-1:0] cr;
        logic [CNT_W-1:0] cf;
        logic [CW_BITS-1:0] cw;
        logic [CW_BITS-1:0] ctl;
        logic conv;
        logic [CNT_W-1:0] kf;
        logic conv_mode8;
        logic conv_se;
        logic [1:0] conv_pw;
        logic [RES_W-1:0] res;
        logic pen_en;
        logic alert_hold;
        logic alert_oe;
        logic powered;
        logic busy;
        logic sdo;
        logic sdo_oe;
        logic busy_oe;
        logic sw_on;
        logic hold;
        logic [2:0] channel;
        logic se;
    } tsp_state_type;

    tsp_state_type st;
    tsp_state_type next_st;

    logic sclk_s;
    logic cs_n_s;
    logic sdi_s;
    logic touch_s;
    logic [31:0] ctrl_reg;
    logic [31:0] test_reg;
    logic [31:0] status_word;
    logic rise;
    logic fall;
    logic [CNT_W-1:0] rearm;
    logic [CNT_W-1:0] conv_end;
    logic [CNT_W-1:0] cr_inc;
    logic [CNT_W-1:0] cf_inc;
    logic [CNT_W-1:0] kf_inc;
    logic [CW_BITS-1:0] cw_shift;
    logic [RES_W-1:0] sample;

    // ==========================================================
    // Pin synchronisers and register slave
    tsp_sync #(
        .WIDTH(4),
        .RESET_VAL(PIN_IDLE)
    ) u_sync (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .async_in({serial_clock_in, chip_select_n_in, serial_data_in,
                   pen_touch_in}),
        .sync_out({sclk_s, cs_n_s, sdi_s, touch_s})
    );

    assign status_word = {18'h00000, st.ctl, st.powered, st.pen_en,
                          st.busy, st.conv, st.capturing, st.active};

    tsp_axi_slave u_regs (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .axi_req_in(axi_req_in),
        .axi_rsp_out(axi_rsp_out),
        .status_in(status_word),
        .ctrl_out(ctrl_reg),
        .test_out(test_reg)
    );

    // ==========================================================
    // Helpers
    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        return (v == CNT_MAX) ? v : v + EDGE_FIRST;
    endfunction

    assign rise = sclk_s && !st.sclk_d;
    assign fall = !sclk_s && st.sclk_d;
    // fifteen-clock overlap
    // The rearm distance follows the word currently in the register.
    assign rearm = st.ctl[RES_POS] ? REARM_8 : REARM_12;
    assign conv_end = EDGE_WORD + (st.conv_mode8 ? LEN_8 : LEN_12);
    assign cr_inc = sat_inc(st.cr);
    assign cf_inc = sat_inc(st.cf);
    assign kf_inc = sat_inc(st.kf);
    assign cw_shift = {st.cw[CW_BITS-2:0], sdi_s};
    // The test pattern lets software exercise the pins without the core.
    assign sample = ctrl_reg[CTRL_TEST_POS] ? test_reg[RES_W-1:0]
                                            : conv_result_in;

    // ==========================================================
    // Sequencer
    always_comb begin
        next_st = st;
        next_st.sclk_d = sclk_s;
        next_st.active = !cs_n_s;
        next_st.sdo_oe = !cs_n_s;
        next_st.busy_oe = !cs_n_s;
        if (cs_n_s) begin
            next_st.capturing = 1'b0;
            next_st.conv = 1'b0;
            next_st.busy = 1'b0;
            next_st.sdo = 1'b0;
            next_st.hold = 1'b0;
            next_st.sw_on = 1'b0;
            next_st.alert_hold = 1'b0;
            next_st.pen_en = !st.ctl[PW_LO_POS];
        end else if (rise) begin
            if (st.capturing && st.cr < EDGE_WORD) begin
                next_st.cw = cw_shift;
                next_st.cr = cr_inc;
                if (cr_inc == EDGE_CH) begin
                    next_st.channel = cw_shift[2:0];
                end
                if (cr_inc == EDGE_ACQ) begin
                    next_st.se = cw_shift[0];
                    next_st.sw_on = 1'b1;
                end
                if (cr_inc == EDGE_WORD) begin
                    next_st.ctl = cw_shift;
                    if (cw_shift[PW_HI_POS]) begin
                        next_st.powered = 1'b1;
                    end
                end
            end else if (sdi_s && (!st.capturing || st.cr >= rearm)) begin
                next_st.capturing = 1'b1;
                next_st.cr = EDGE_FIRST;
                next_st.cf = '0;
                next_st.cw = {{(CW_BITS-1){1'b0}}, 1'b1};
                next_st.pen_en = 1'b0;
                next_st.alert_hold = st.alert_oe;
            end else if (st.capturing) begin
                next_st.cr = cr_inc;
            end
        end else if (fall) begin
            if (st.capturing) begin
                next_st.cf = cf_inc;
                if (cf_inc == EDGE_PWR) begin
                    next_st.powered = 1'b1;
                end
                if (cf_inc == EDGE_ALERT) begin
                    next_st.alert_hold = 1'b0;
                end
            end
            next_st.busy = 1'b0;
            next_st.sdo = 1'b0;
            if (st.capturing && cf_inc == EDGE_WORD && st.cr >= EDGE_WORD) begin
                next_st.conv = 1'b1;
                next_st.kf = EDGE_WORD;
                next_st.busy = 1'b1;
                next_st.hold = 1'b1;
                next_st.conv_mode8 = st.ctl[RES_POS];
                next_st.conv_se = st.ctl[SE_POS];
                next_st.conv_pw = st.ctl[PW_HI_POS:PW_LO_POS];
                next_st.res = sample;
                if (st.ctl[SE_POS]) begin
                    next_st.sw_on = 1'b0;
                end
            end else if (st.conv) begin
                next_st.kf = kf_inc;
                if (kf_inc >= EDGE_MSB) begin
                    next_st.sdo = st.res[RES_W-1];
                    next_st.res = {st.res[RES_W-2:0], 1'b0};
                end
                if (kf_inc == conv_end) begin
                    next_st.conv = 1'b0;
                    next_st.hold = 1'b0;
                    next_st.sw_on = 1'b0;
                    // pen and power per word
                    // A start bit seen during this conversion already
                    // owns pen and power, so they are left to its word.
                    if (cf_inc > EDGE_WORD) begin
                        next_st.pen_en = !st.conv_pw[PW_LO_POS];
                        if (!st.conv_pw[PW_HI_POS]) begin
                            next_st.powered = 1'b0;
                        end
                    end
                end
            end
        end
        next_st.alert_oe = (st.pen_en && touch_s) || next_st.alert_hold;
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st <= '0;
            st.pen_en <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    assign serial_data_out = st.sdo;
    assign serial_data_oe_out = st.sdo_oe;
    assign busy_out = st.busy;
    assign busy_oe_out = st.busy_oe;
    assign touch_alert_n_out = 1'b0;
    assign touch_alert_n_oe_out = st.alert_oe;
    assign channel_select_out = st.channel;
    assign single_ended_select_out = st.se;
    assign switch_on_out = st.sw_on;
    assign track_hold_out = st.hold;
    assign power_up_out = st.powered;

    // ==========================================================
    // Checks
    a_select_enables: assert property (
        @(posedge core_clk_in) disable iff (!arst_n_in)
        $fell(cs_n_s) |=> (serial_data_oe_out && busy_oe_out))
        else $error("outputs not enabled after select fell");

    a_start_needed: assert property (
        @(posedge core_clk_in) disable iff (!arst_n_in)
        (!cs_n_s && rise && !st.capturing && !sdi_s) |=> !st.capturing)
        else $error("sequence began without a start bit");

    a_word_launch: assert property (
        @(posedge core_clk_in) disable iff (!arst_n_in)
        (!cs_n_s && fall && st.capturing && st.cf == 5'h07
         && st.cr >= EDGE_WORD)
        |=> (st.conv && busy_out && track_hold_out))
        else $error("conversion did not start on eighth falling edge");

    a_busy_short: assert property (
        @(posedge core_clk_in) disable iff (!arst_n_in)
        (busy_out && fall && !cs_n_s && !(st.capturing && cf_inc ==
         EDGE_WORD)) |=> !busy_out)
        else $error("busy outlived its falling edge");

    a_low_in_word: assert property (
        @(posedge core_clk_in) disable iff (!arst_n_in)
        (st.capturing && st.cr < EDGE_WORD && !st.conv && $past(fall)
         && !$past(st.conv)) |-> !serial_data_out)
        else $error("data output not low during control word");

    a_ratio_switch: assert property (
        @(posedge core_clk_in) disable iff (!arst_n_in)
        (st.conv && !st.conv_se) |-> switch_on_out)
        else $error("ratiometric switches off while converting");

    a_deselect_abort: assert property (
        @(posedge core_clk_in) disable iff (!arst_n_in)
        cs_n_s |=> (!st.conv && !serial_data_oe_out && !busy_oe_out))
        else $error("deselect did not abort and float");

    a_rearm_twelve: assert property (
        @(posedge core_clk_in) disable iff (!arst_n_in)
        (!cs_n_s && rise && st.capturing && !st.ctl[RES_POS]
         && st.cr >= EDGE_WORD && st.cr < REARM_12) |=> st.cr != EDGE_FIRST)
        else $error("start bit accepted too early in twelve-bit mode");

    a_power_edge: assert property (
        @(posedge core_clk_in) disable iff (!arst_n_in)
        (!cs_n_s && fall && st.capturing && st.cf == 5'h03) |=> power_up_out)
        else $error("not powered after fourth falling edge");

    a_pen_off: assert property (
        @(posedge core_clk_in) disable iff (!arst_n_in)
        (!cs_n_s && rise && !st.capturing && sdi_s) |=> !st.pen_en)
        else $error("start bit left pen detection enabled");

    a_alert_release: assert property (
        @(posedge core_clk_in) disable iff (!arst_n_in)
        (!cs_n_s && fall && st.capturing && st.cf == 5'h03 && !st.pen_en)
        |=> !touch_alert_n_oe_out)
        else $error("alert not released at fourth falling edge");
endmodule

/* verif/tsp_host_model.sv */
// Host model that drives the serial clock, select and control bits.
`timescale 1ns/10ps
module tsp_host_model (
    // Clock
    input wire logic core_clk_in,
    // Serial pins
    output logic sclk_out,
    output logic cs_n_out,
    output logic sdi_out,
    input wire logic sdo_in,
    input wire logic busy_in,
    input wire logic alert_n_in,
    input wire logic power_in,
    input wire logic hold_in,
    input wire logic sw_in
);
    logic [1:40] dout;
    logic [1:40] hld;
    logic [1:40] swa;
    logic [1:40] busy;
    logic [1:40] alert;
    logic [1:40] pwr;

    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out = 1'b0;
    end

    // ==========================================================
    // Frame of n serial clocks; the clock stands low between frames.
    // host bit timing
    task automatic run(input logic [1:40] din, input int n);
        dout = '0;
        busy = '0;
        alert = '0;
        pwr = '0;
        hld = '0;
        swa = '0;
        @(posedge core_clk_in);
        cs_n_out <= 1'b0;
        repeat (8) @(posedge core_clk_in);
        for (int i = 1; i <= n; i++) begin
            sclk_out <= 1'b0;
            sdi_out <= din[i];
            repeat (4) @(posedge core_clk_in);
            sclk_out <= 1'b1;
            repeat (3) @(posedge core_clk_in);
            @(negedge core_clk_in);
            dout[i] = sdo_in;
            busy[i] = busy_in;
            alert[i] = alert_n_in;
            pwr[i] = power_in;
            hld[i] = hold_in;
            swa[i] = sw_in;
            @(posedge core_clk_in);
            if (n == 24 && i % 8 == 0) begin
                sclk_out <= 1'b0;
                repeat (8) @(posedge core_clk_in);
            end
        end
        sclk_out <= 1'b0;
        repeat (8) @(posedge core_clk_in);
        cs_n_out <= 1'b1;
        // A released line shows the inverse, not a stale value.
        sdi_out <= ~sdi_out;
        repeat (8) @(posedge core_clk_in);
    endtask
endmodule

/* verif/tb_top.sv */
// Self-checking bench of the touch ADC serial port.
`timescale 1ns/10ps
module tb_top;
    import tsp_pkg::*;
    logic clk, rst_n, sclk, cs_n, sdi, pen, sdo, sdo_oe, busy, busy_oe;
    logic alert, alert_oe, se, sw, th, pwr;
    logic [2:0] ch;
    logic [11:0] res;
    logic [31:0] q;
    logic [1:0] r;
    tsp_axi_req_type req;
    tsp_axi_rsp_type rsp;
    wire logic sdo_w;
    wire logic busy_w;
    wire logic alert_w;
    int error_cnt;
    int checked;

    assign sdo_w = sdo_oe ? sdo : 1'bz;
    assign busy_w = busy_oe ? busy : 1'bz;
    // The alert line has a pull-up, so it reads high when released.
    assign alert_w = alert_oe ? alert : 1'b1;

    tsp_top tsp_top_inst (.core_clk_in(clk), .arst_n_in(rst_n),
        .axi_req_in(req), .axi_rsp_out(rsp), .serial_clock_in(sclk),
        .chip_select_n_in(cs_n), .serial_data_in(sdi),
        .serial_data_out(sdo), .serial_data_oe_out(sdo_oe),
        .busy_out(busy), .busy_oe_out(busy_oe),
        .touch_alert_n_out(alert), .touch_alert_n_oe_out(alert_oe),
        .conv_result_in(res), .pen_touch_in(pen),
        .channel_select_out(ch), .single_ended_select_out(se),
        .switch_on_out(sw), .track_hold_out(th), .power_up_out(pwr));

    tsp_host_model tsp_host_model_inst (.core_clk_in(clk),
        .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi), .sdo_in(sdo_w),
        .busy_in(busy_w), .alert_n_in(alert_w), .power_in(pwr),
        .hold_in(th), .sw_in(sw));

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic axi(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        logic ta, tw, tv;
        int n;
        tv = 1'b0;
        n = 0;
        @(posedge clk);
        req.awvalid <= wr;
        req.wvalid <= wr;
        req.bready <= wr;
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.arvalid <= !wr;
        req.rready <= !wr;
        req.araddr <= a;
        while (!tv && n < 200) begin
            @(negedge clk);
            ta = wr ? rsp.awready : rsp.arready;
            tw = rsp.wready;
            tv = wr ? rsp.bvalid : rsp.rvalid;
            q = rsp.rdata;
            r = wr ? rsp.bresp : rsp.rresp;
            @(posedge clk);
            if (ta) begin
                req.awvalid <= 1'b0;
                req.arvalid <= 1'b0;
            end
            if (tw) req.wvalid <= 1'b0;
            if (tv) begin
                req.bready <= 1'b0;
                req.rready <= 1'b0;
            end
            n++;
        end
        chk({39'h0, tv}, 40'h1);
    endtask

    task automatic frame(input logic [7:0] cw, input int n);
        tsp_host_model_inst.run({cw, 32'h0}, n);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_pen;
        chk({39'h0, alert_w}, 40'h0);
        frame(8'h82, 24);
        chk(tsp_host_model_inst.swa, {5'h0, 15'h7FFF, 20'h0});
        chk({38'h0, tsp_host_model_inst.alert[4:5]}, 40'h1);
        chk({39'h0, alert_w}, 40'h0);
        frame(8'h81, 24);
        chk({38'h0, alert_w, pwr}, 40'h2);
        frame(8'h80, 24);
        chk({38'h0, tsp_host_model_inst.pwr[4:5]}, 40'h1);
        chk({38'h0, alert_w, pwr}, 40'h0);
        pen <= 1'b0;
        repeat (4) @(posedge clk);
        chk({39'h0, alert_w}, 40'h1);
        pen <= 1'b1;
    endtask

    task automatic t_basic;
        frame(8'hD6, 24);
        chk(tsp_host_model_inst.dout, {9'h0, res, 19'h0});
        chk(tsp_host_model_inst.busy, {8'h0, 1'b1, 31'h0});
        chk(tsp_host_model_inst.hld, {8'h0, 12'hFFF, 20'h0});
        chk(tsp_host_model_inst.swa, {5'h0, 3'h7, 32'h0});
        chk({35'h0, ch, se, pwr}, {35'h0, 3'h5, 2'h3});
    endtask

    task automatic t_nostart_abort;
        tsp_host_model_inst.run(40'h0, 24);
        chk(tsp_host_model_inst.dout | tsp_host_model_inst.busy, 0);
        chk({37'h0, ch}, 40'h5);
        frame(8'hD6, 12);
        chk({38'h0, sdo_oe, busy_oe}, 40'h0);
        t_basic();
    endtask

    task automatic t_overlap;
        tsp_host_model_inst.run({8'hB3, 6'h0, 1'b1, 8'hB3, 17'h0}, 36);
        chk(tsp_host_model_inst.dout,
            {9'h0, res, 3'h0, res, 4'h0});
        chk({35'h0, ch, se, pwr}, {35'h0, 3'h3, 2'h1});
        tsp_host_model_inst.run({8'h9A, 3'h0, 8'h9A, 21'h0}, 28);
        chk(tsp_host_model_inst.dout,
            {9'h0, res[11:4], 3'h0, res[11:4], 12'h0});
    endtask

    task automatic t_regs;
        axi(1'b1, REG_CTRL, 32'h1);
        chk({38'h0, r}, {38'h0, RESP_OKAY});
        axi(1'b1, REG_TEST, 32'h3C9);
        axi(1'b0, REG_TEST, 32'h0);
        chk({28'h0, q[11:0]}, 40'h3C9);
        frame(8'hD6, 24);
        chk(tsp_host_model_inst.dout, {9'h0, 12'h3C9, 19'h0});
        axi(1'b0, 4'hC, 32'h0);
        chk({38'h0, r}, {38'h0, RESP_DECERR});
        axi(1'b0, REG_STATUS, 32'h0);
        chk({32'h0, q[13:6]}, 40'hD6);
        axi(1'b1, REG_CTRL, 32'h0);
    endtask

    task automatic report_and_stop;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Generous bound: the whole sequence needs well under a third of it.
    initial begin
        #1500000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        error_cnt = 0;
        checked = 0;
        rst_n = 1'b0;
        pen = 1'b0;
        res = 12'hA5C;
        req = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        pen <= 1'b1;
        repeat (8) @(posedge clk);
        t_pen();
        t_basic();
        t_nostart_abort();
        t_overlap();
        t_regs();
        report_and_stop();
    end
endmodule
